// ===== core/cpat_bridge.sv
// processor to pci address decode and translation, inbound window translation
`timescale 1ns/1ns
`default_nettype none
`include "cpat_regs.svh"
// Functional notes
// - address bits 33:32 choose memory, local, sparse or dense quadrant
// - in quadrant 01, bits 31:29 101/110/111 pick iack, i/o, config windows
// - an aligned load or store of defined size hitting a pci window starts a pci transaction
// - pci side is a valid/ready descriptor handshake; request held until engine takes it
// - encoded accesses use bits 4:3 as size, bits 28:7 onto pci 23:2
// - sparse access with bits 31:29 zero drives pci 31:27 as zero
// - sparse access with nonzero bits 31:29 takes pci 31:27 from extension
// - sparse memory: pci 26:24 from 31:29, 23:2 from 28:7, commands 0111/0110
// - iack window: extension high bits; read is iack 0000, write special 0001
// - i/o and config zero pci 31:24; config low bits from cycle-type field
// - bits 6:5 and 4:3 give active-low byte enables per size
// - low pci address bits 00 for memory, bits 6:5 for i/o cycles
// - two inbound windows translate 32-bit pci to 34-bit memory address
// - map select bit chooses direct (0) or scatter-gather (1) translation
// - dense quadrant maps address unchanged, extension ignored
// - dense transfers are unmasked longword or quadword only
module cpat_bridge #(
	parameter int NUM_WIN = 2
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic cpu_valid_in,
	input wire cpat_pkg::cpat_cpu_req_t cpu_req_in,
	output logic cpu_ready_out,
	output logic pci_valid_out,
	output cpat_pkg::cpat_pci_req_t pci_req_out,
	input wire logic pci_ready_in,
	output logic local_valid_out,
	output logic [33:0] local_addr_out,
	output logic local_write_out,
	input wire logic tgt_valid_in,
	input wire logic [31:0] tgt_addr_in,
	output logic tgt_done_out,
	output cpat_pkg::cpat_tgt_res_t tgt_res_out,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out
);
	import cpat_pkg::*;

	if (NUM_WIN < 1 || NUM_WIN > 8) begin : g_chk
		$error("NUM_WIN must lie between 1 and 8");
	end

	cpat_state_t state_q;
	logic [31:0] ctrl_q;
	cpat_win_cfg_t win_q [NUM_WIN];
	cpat_tgt_res_t win_res [NUM_WIN];
	logic err_q;
	logic [33:0] last_q;
	logic pci_valid_q;
	cpat_pci_req_t pci_req_q;
	logic local_valid_q;
	logic [33:0] local_addr_q;
	logic local_write_q;
	logic tgt_done_q;
	cpat_tgt_res_t tgt_res_q;
	logic [31:0] rdata_q;
	logic [4:0] uae;
	logic [1:0] cfg_type;
	logic [1:0] quad;
	logic [2:0] hi;
	logic [3:0] be_l;
	logic be_ok;
	logic is_pci;
	logic req_err;
	cpat_pci_req_t desc;
	cpat_tgt_res_t sel_res;
	logic accept;

	assign uae = ctrl_q[`CPAT_CTRL_UAE_MSB:`CPAT_CTRL_UAE_LSB];
	assign cfg_type = ctrl_q[`CPAT_CTRL_CFG_MSB:`CPAT_CTRL_CFG_LSB];
	assign quad = cpu_req_in.addr[33:32];
	assign hi = cpu_req_in.addr[31:29];
	// no queue: one processor request is in flight at a time
	assign cpu_ready_out = (state_q == ST_IDLE);
	assign accept = cpu_valid_in && cpu_ready_out;

	// byte enables of the encoded spaces
	always_comb begin
		be_l = 4'hF;
		be_ok = 1'b1;
		case ({cpu_req_in.addr[4:3], cpu_req_in.addr[6:5]})
			4'h0: be_l = 4'hE;
			4'h1: be_l = 4'hD;
			4'h2: be_l = 4'hB;
			4'h3: be_l = 4'h7;
			4'h4: be_l = 4'hC;
			4'h5: be_l = 4'h9;
			4'h6: be_l = 4'h3;
			4'h8: be_l = 4'h8;
			4'h9: be_l = 4'h1;
			4'hC, 4'hF: be_l = 4'h0;
			default: be_ok = 1'b0;
		endcase
	end

	// address and command build
	always_comb begin
		is_pci = 1'b1;
		desc.be_l = be_l;
		desc.beats = 2'h1;
		desc.cmd = cpu_req_in.write ? `CPAT_CMD_MEMW : `CPAT_CMD_MEMR;
		desc.addr = {uae, hi, cpu_req_in.addr[28:7], 2'h0};
		case (quad)
			`CPAT_Q_SPARSE: begin
				if (hi == 3'h0) begin
					desc.addr[31:27] = 5'h00;
				end // else keeps the extension
				if (cpu_req_in.addr[6:3] == 4'hF) begin
					desc.beats = 2'h2;
				end
			end
			`CPAT_Q_DENSE: begin
				desc.addr = {cpu_req_in.addr[31:2], 2'h0};
				desc.be_l = 4'h0;
				desc.beats = cpu_req_in.quad ? 2'h2 : 2'h1;
			end
			`CPAT_Q_LOCAL: begin
				case (hi)
					`CPAT_W_IACK: begin
						desc.cmd = cpu_req_in.write ? `CPAT_CMD_SPEC : `CPAT_CMD_IACK;
					end
					`CPAT_W_IO: begin
						desc.addr = {8'h00, cpu_req_in.addr[28:7], cpu_req_in.addr[6:5]};
						desc.cmd = cpu_req_in.write ? `CPAT_CMD_IOW : `CPAT_CMD_IOR;
					end
					`CPAT_W_CFG: begin
						desc.addr = {8'h00, cpu_req_in.addr[28:7], cfg_type};
						desc.cmd = cpu_req_in.write ? `CPAT_CMD_CFGW : `CPAT_CMD_CFGR;
					end
					default: is_pci = 1'b0;
				endcase
			end
			default: is_pci = 1'b0;
		endcase
		// misaligned or undefined size codes are dropped, not sent
		req_err = is_pci && ((cpu_req_in.addr[2:0] != 3'h0) ||
			(quad != `CPAT_Q_DENSE && !be_ok));
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			pci_valid_q <= 1'b0;
			pci_req_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept && is_pci && !req_err) begin
						pci_valid_q <= 1'b1;
						pci_req_q <= desc;
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (pci_ready_in) begin
						pci_valid_q <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			local_valid_q <= 1'b0;
			local_addr_q <= '0;
			local_write_q <= 1'b0;
		end else begin
			local_valid_q <= accept && !is_pci;
			if (accept && !is_pci) begin
				local_addr_q <= cpu_req_in.addr;
				local_write_q <= cpu_req_in.write;
			end
		end
	end

	// inbound windows, lower index wins on overlap
	for (genvar i = 0; i < NUM_WIN; i++) begin : g_win
		cpat_window u_win (
			.cfg_in(win_q[i]),
			.pci_addr_in(tgt_addr_in),
			.res_out(win_res[i])
		);
	end

	always_comb begin
		sel_res = '0;
		for (int i = NUM_WIN - 1; i >= 0; i--) begin
			if (win_res[i].hit) begin
				sel_res = win_res[i];
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			tgt_done_q <= 1'b0;
			tgt_res_q <= '0;
		end else begin
			tgt_done_q <= tgt_valid_in;
			if (tgt_valid_in) begin
				tgt_res_q <= sel_res;
			end
		end
	end

	// register writes
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ctrl_q <= `CPAT_CTRL_RST;
			for (int i = 0; i < NUM_WIN; i++) begin
				win_q[i] <= {`CPAT_WIN_RST, `CPAT_WIN_RST, `CPAT_WIN_RST};
			end
		end else if (reg_wr_in) begin
			if (reg_addr_in == `CPAT_OFF_CTRL) begin
				ctrl_q <= reg_wdata_in;
			end
			for (int i = 0; i < NUM_WIN; i++) begin
				if (reg_addr_in == 8'(`CPAT_OFF_WIN + i * `CPAT_WIN_STRIDE + `CPAT_WIN_BASE)) begin
					win_q[i].base <= reg_wdata_in;
				end
				if (reg_addr_in == 8'(`CPAT_OFF_WIN + i * `CPAT_WIN_STRIDE + `CPAT_WIN_MASK)) begin
					win_q[i].mask <= reg_wdata_in;
				end
				if (reg_addr_in == 8'(`CPAT_OFF_WIN + i * `CPAT_WIN_STRIDE + `CPAT_WIN_TBASE)) begin
					win_q[i].tbase <= reg_wdata_in;
				end
			end
		end
	end

	// sticky error: a new fault in the clearing cycle wins
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			err_q <= 1'b0;
			last_q <= '0;
		end else begin
			if (accept && req_err) begin
				err_q <= 1'b1;
			end else if (reg_wr_in && reg_addr_in == `CPAT_OFF_STATUS &&
				reg_wdata_in[`CPAT_ST_ERR_BIT]) begin
				err_q <= 1'b0;
			end
			if (accept) begin
				last_q <= cpu_req_in.addr;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_q <= '0;
		end else if (reg_rd_in) begin
			rdata_q <= '0;
			if (reg_addr_in == `CPAT_OFF_CTRL) begin
				rdata_q <= ctrl_q;
			end
			if (reg_addr_in == `CPAT_OFF_STATUS) begin
				rdata_q[`CPAT_ST_BUSY_BIT] <= (state_q == ST_WAIT);
				rdata_q[`CPAT_ST_ERR_BIT] <= err_q;
			end
			if (reg_addr_in == `CPAT_OFF_LAST) begin
				rdata_q <= last_q[31:0];
			end
			for (int i = 0; i < NUM_WIN; i++) begin
				if (reg_addr_in == 8'(`CPAT_OFF_WIN + i * `CPAT_WIN_STRIDE + `CPAT_WIN_BASE)) begin
					rdata_q <= win_q[i].base;
				end
				if (reg_addr_in == 8'(`CPAT_OFF_WIN + i * `CPAT_WIN_STRIDE + `CPAT_WIN_MASK)) begin
					rdata_q <= win_q[i].mask;
				end
				if (reg_addr_in == 8'(`CPAT_OFF_WIN + i * `CPAT_WIN_STRIDE + `CPAT_WIN_TBASE)) begin
					rdata_q <= win_q[i].tbase;
				end
			end
		end
	end

	assign pci_valid_out = pci_valid_q;
	assign pci_req_out = pci_req_q;
	assign local_valid_out = local_valid_q;
	assign local_addr_out = local_addr_q;
	assign local_write_out = local_write_q;
	assign tgt_done_out = tgt_done_q;
	assign tgt_res_out = tgt_res_q;
	assign reg_rdata_out = rdata_q;

	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	logic [4:0] uae_acc_q;
	always_ff @(posedge core_clk_in) begin
		if (accept) begin
			uae_acc_q <= uae;
		end
	end
	logic sp_q;
	assign sp_q = (last_q[33:32] == `CPAT_Q_SPARSE);

	property p_quadrant;
		pci_valid_out |-> last_q[33:32] != `CPAT_Q_MEM;
	endproperty
	a_quadrant: assert property (p_quadrant) else $error("pci cycle from memory quadrant");
	property p_start;
		accept && is_pci && !req_err |=> pci_valid_out && state_q == ST_WAIT;
	endproperty
	a_start: assert property (p_start) else $error("pci window access did not start");
	property p_hold;
		pci_valid_out && !pci_ready_in |=> pci_valid_out && $stable(pci_req_out);
	endproperty
	a_hold: assert property (p_hold) else $error("pci request dropped before taken");
	property p_shift;
		pci_valid_out && (sp_q || last_q[33:29] == 5'h0E) |->
			pci_req_out.addr[23:2] == last_q[28:7];
	endproperty
	a_shift: assert property (p_shift) else $error("encoded address shift wrong");
	property p_low16;
		pci_valid_out && sp_q && last_q[31:29] == 3'h0 |-> pci_req_out.addr[31:27] == 5'h00;
	endproperty
	a_low16: assert property (p_low16) else $error("low region extension not zero");
	property p_ext;
		pci_valid_out && sp_q && last_q[31:29] != 3'h0 |->
			pci_req_out.addr[31:27] == uae_acc_q && pci_req_out.addr[26:24] == last_q[31:29];
	endproperty
	a_ext: assert property (p_ext) else $error("extension bits wrong");
	property p_iack;
		accept && !req_err && quad == `CPAT_Q_LOCAL && hi == `CPAT_W_IACK && !cpu_req_in.write
			|=> pci_req_out.cmd == 4'h0 ##1 pci_req_out.cmd == 4'h0 || !pci_valid_out;
	endproperty
	a_iack: assert property (p_iack) else $error("iack command wrong");
	property p_io;
		pci_valid_out && last_q[33:29] == 5'h0E |->
			pci_req_out.addr[31:24] == 8'h00 && pci_req_out.addr[1:0] == last_q[6:5];
	endproperty
	a_io: assert property (p_io) else $error("i/o address build wrong");
	property p_be;
		accept && !req_err && quad == `CPAT_Q_SPARSE && cpu_req_in.addr[6:3] == 4'hC
			|=> pci_req_out.be_l == 4'h7 && pci_req_out.addr[1:0] == 2'h0;
	endproperty
	a_be: assert property (p_be) else $error("byte lane enable wrong");
	property p_dense;
		pci_valid_out && last_q[33:32] == `CPAT_Q_DENSE |->
			pci_req_out.addr == {last_q[31:2], 2'h0} && pci_req_out.be_l == 4'h0;
	endproperty
	a_dense: assert property (p_dense) else $error("dense mapping wrong");
	property p_local;
		accept && quad == `CPAT_Q_LOCAL && hi < `CPAT_W_IACK |=> local_valid_out && !pci_valid_out;
	endproperty
	a_local: assert property (p_local) else $error("local access reached pci");
	property p_sg;
		tgt_valid_in && win_res[0].hit |=> tgt_done_out && tgt_res_out.sg == win_q[0].base[1];
	endproperty
	a_sg: assert property (p_sg) else $error("map select not honoured");
	c_sparse: cover property (pci_valid_out && sp_q && pci_ready_in);
	c_cfg: cover property (pci_valid_out && pci_req_out.cmd == 4'hA);
	c_tgt: cover property (tgt_done_out && tgt_res_out.hit);
endmodule // cpat_bridge
`default_nettype wire

// ===== core/cpat_window.sv
// one inbound target window: match and direct or mapped translation
`timescale 1ns/1ns
`default_nettype none
`include "cpat_regs.svh"
module cpat_window (
	input wire cpat_pkg::cpat_win_cfg_t cfg_in,
	input wire logic [31:0] pci_addr_in,
	output cpat_pkg::cpat_tgt_res_t res_out
);
	import cpat_pkg::*;
	logic [31:0] offs;
	logic [31:0] pte;
	// mask ones mark the offset bits inside the window
	assign offs = pci_addr_in & cfg_in.mask;
	// mapped mode: eight-byte entry per 8 KB page, walk done elsewhere
	assign pte = (cfg_in.tbase & ~32'h0000_0007) + {10'h000, offs[31:13], 3'h0};
	always_comb begin
		res_out.hit = cfg_in.base[`CPAT_WBASE_EN_BIT] &&
			((pci_addr_in & ~cfg_in.mask & ~32'h0000_0003) ==
			(cfg_in.base & ~cfg_in.mask & ~32'h0000_0003));
		res_out.sg = cfg_in.base[`CPAT_WBASE_MSEL_BIT];
		if (cfg_in.base[`CPAT_WBASE_MSEL_BIT]) begin
			res_out.addr = {2'h0, pte};
		end else begin
			// pci masters reach only the memory quadrant
			res_out.addr = {2'h0, (cfg_in.tbase & ~cfg_in.mask) | offs};
		end
	end
endmodule // cpat_window
`default_nettype wire

// ===== inc/cpat_pkg.sv
// types shared by the address translator modules
`default_nettype none
package cpat_pkg;
	typedef enum logic {ST_IDLE, ST_WAIT} cpat_state_t;
	typedef struct packed {
		logic [33:0] addr;
		logic write;
		logic quad;
	} cpat_cpu_req_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [3:0] be_l;
		logic [1:0] beats;
	} cpat_pci_req_t;
	typedef struct packed {
		logic [31:0] base;
		logic [31:0] mask;
		logic [31:0] tbase;
	} cpat_win_cfg_t;
	typedef struct packed {
		logic hit;
		logic sg;
		logic [33:0] addr;
	} cpat_tgt_res_t;
endpackage
`default_nettype wire

// ===== inc/cpat_regs.svh
// register offsets, field positions, reset values and encodings of the address translator
`ifndef CPAT_REGS_SVH
`define CPAT_REGS_SVH
`define CPAT_OFF_CTRL 8'h00
`define CPAT_OFF_STATUS 8'h04
`define CPAT_OFF_LAST 8'h08
`define CPAT_OFF_WIN 8'h10
`define CPAT_WIN_STRIDE 8'h10
`define CPAT_WIN_BASE 8'h00
`define CPAT_WIN_MASK 8'h04
`define CPAT_WIN_TBASE 8'h08
`define CPAT_CTRL_UAE_MSB 31
`define CPAT_CTRL_UAE_LSB 27
`define CPAT_CTRL_CFG_MSB 1
`define CPAT_CTRL_CFG_LSB 0
`define CPAT_WBASE_EN_BIT 0
`define CPAT_WBASE_MSEL_BIT 1
`define CPAT_ST_BUSY_BIT 0
`define CPAT_ST_ERR_BIT 1
`define CPAT_CTRL_RST 32'h0000_0000
`define CPAT_WIN_RST 32'h0000_0000
`define CPAT_Q_MEM 2'h0
`define CPAT_Q_LOCAL 2'h1
`define CPAT_Q_SPARSE 2'h2
`define CPAT_Q_DENSE 2'h3
`define CPAT_W_IACK 3'h5
`define CPAT_W_IO 3'h6
`define CPAT_W_CFG 3'h7
`define CPAT_CMD_IACK 4'h0
`define CPAT_CMD_SPEC 4'h1
`define CPAT_CMD_IOR 4'h2
`define CPAT_CMD_IOW 4'h3
`define CPAT_CMD_MEMR 4'h6
`define CPAT_CMD_MEMW 4'h7
`define CPAT_CMD_CFGR 4'hA
`define CPAT_CMD_CFGW 4'hB
`endif

// ===== verif/cpat_pci_model.sv
// pci engine stand-in that takes descriptors after a chosen stall
`timescale 1ns/1ns
`default_nettype none
module cpat_pci_model (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic valid_in,
	input wire logic [1:0] stall_in,
	output logic ready_out
);
	logic [1:0] cnt_q;
	// ready only while a descriptor is offered; dropped after each take so no stale accept
	always_ff @(posedge core_clk_in) begin
		if (rst_in || ready_out) begin
			ready_out <= 1'b0;
			cnt_q <= 2'h0;
		end else if (valid_in) begin
			if (cnt_q >= stall_in) begin
				ready_out <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule // cpat_pci_model
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the address translator
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import cpat_pkg::*;
	logic clk = 0, rst = 1, cv = 0, tv = 0, wr = 0, rd = 0, crdy, pv, prdy, lv, lw, td;
	cpat_cpu_req_t creq = '0;
	cpat_pci_req_t preq;
	cpat_tgt_res_t tres;
	logic [33:0] la;
	logic [31:0] taddr = 0, wd = 0, rdat, rdat_dut;
	logic [7:0] ra = 0;
	logic [1:0] stall = 0, cfg = 0;
	logic [4:0] ext = 0;
	int err_total = 0, cmp_count = 0, cyc = 0;
	logic [31:0] wb [2], wm [2], wt [2];
	logic [3:0] codes [11] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1, 4'h5, 4'h9, 4'h2, 4'h6, 4'h3, 4'hF};

	cpat_bridge u_dut (
		.core_clk_in(clk), .rst_in(rst), .cpu_valid_in(cv), .cpu_req_in(creq),
		.cpu_ready_out(crdy), .pci_valid_out(pv), .pci_req_out(preq), .pci_ready_in(prdy),
		.local_valid_out(lv), .local_addr_out(la), .local_write_out(lw),
		.tgt_valid_in(tv), .tgt_addr_in(taddr), .tgt_done_out(td), .tgt_res_out(tres),
		.reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat_dut)
	);
	cpat_pci_model u_pci (
		.core_clk_in(clk), .rst_in(rst), .valid_in(pv), .stall_in(stall), .ready_out(prdy)
	);

	initial begin
		forever #2 clk = ~clk;
	end

	task automatic tally_and_finish;
		if (err_total == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// hang guard; a full run needs well under two thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish;
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1;
		ra <= a;
		@(posedge clk);
		rd <= 0;
		@(posedge clk);
		d = rdat_dut;
	endtask

	function automatic cpat_pci_req_t exp_pci(input logic [33:0] a, input logic w, input logic q);
		cpat_pci_req_t r;
		r.be_l = (a[4:3] == 2'h3) ? 4'h0 : ~(((4'h2 << a[4:3]) - 4'h1) << a[6:5]);
		r.beats = 2'h1;
		if (a[33:32] == 2'h3) begin
			r.addr = {a[31:2], 2'h0};
			r.be_l = 4'h0;
			r.beats = q ? 2'h2 : 2'h1;
			r.cmd = w ? 4'h7 : 4'h6;
		end else if (a[33:32] == 2'h2) begin
			r.addr = {(a[31:29] == 3'h0) ? 5'h0 : ext, a[31:7], 2'h0};
			r.beats = (a[6:3] == 4'hF) ? 2'h2 : 2'h1;
			r.cmd = w ? 4'h7 : 4'h6;
		end else if (a[31:29] == 3'h5) begin
			r.addr = {ext, a[31:7], 2'h0};
			r.cmd = {3'h0, w};
		end else begin
			r.addr = {8'h0, a[28:7], (a[31:29] == 3'h6) ? a[6:5] : cfg};
			r.cmd = {a[29], 2'h1, w};
		end
		return r;
	endfunction

	// kind 0 pci route, 1 local route, 2 dropped as an error
	task automatic cpu_op(input logic [33:0] a, input logic w, input logic q, input int kind);
		int n;
		@(posedge clk);
		cv <= 1;
		creq <= '{a, w, q};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!crdy && n < 50);
		cv <= 0;
		@(posedge clk);
		if (kind == 0) begin
			chk(pv, 1, "pci start");
			n = 0;
			while (!(pv && prdy) && n < 50) begin
				@(posedge clk);
				n++;
			end
			chk(n < 50, 1, "pci take in time");
			chk(preq, exp_pci(a, w, q), "pci descriptor");
		end else if (kind == 1) begin
			chk({pv, lv, lw, la}, {2'b01, w, a}, "local route");
		end else begin
			repeat (3) begin
				chk({pv, lv}, 0, "dropped request");
				@(posedge clk);
			end
		end
	endtask

	task automatic tgt(input logic [31:0] p);
		logic [33:0] e;
		logic h, s;
		e = 0;
		h = 0;
		s = 0;
		for (int i = 1; i >= 0; i--) begin
			if (wb[i][0] && ((p & ~wm[i] & ~32'h3) == (wb[i] & ~wm[i] & ~32'h3))) begin
				h = 1;
				s = wb[i][1];
				e = s ? {2'h0, (wt[i] & ~32'h7) + (((p & wm[i]) >> 13) << 3)}
					: {2'h0, (wt[i] & ~wm[i]) | (p & wm[i])};
			end
		end
		@(posedge clk);
		tv <= 1;
		taddr <= p;
		@(posedge clk);
		tv <= 0;
		@(posedge clk);
		chk({td, tres}, {1'b1, h, s, e}, "inbound");
	endtask

	initial begin
		logic [33:0] a;
		void'($urandom(53966));
		repeat (20) @(posedge clk);
		rst <= 0;
		chk({crdy, pv, lv, td}, 4'h8, "reset outputs");
		reg_rd(8'h00, rdat);
		chk(rdat, 0, "control reset");
		reg_rd(8'hFC, rdat);
		chk(rdat, 0, "unmapped read");
		ext = 5'($urandom);
		cfg = 2'($urandom);
		reg_wr(8'h00, {ext, 25'h0, cfg});
		reg_rd(8'h00, rdat);
		chk(rdat, {ext, 25'h0, cfg}, "control");
		wb = '{32'h4000_0001, 32'h8000_0003};
		wm = '{32'h00FF_FFFF, 32'h0FFF_FFFF};
		wt = '{32'h1200_0000, 32'h0010_0000};
		for (int i = 0; i < 2; i++) begin
			reg_wr(8'(8'h10 + 8'h10 * i), wb[i]);
			reg_wr(8'(8'h14 + 8'h10 * i), wm[i]);
			reg_wr(8'(8'h18 + 8'h10 * i), wt[i]);
		end
		for (int i = 0; i < 12; i++) begin
			taddr <= $urandom;
			@(posedge clk);
			a = {2'h0, taddr};
			if (i % 3 == 0) a[31:24] = 8'h40;
			if (i % 3 == 1) a[31:28] = 4'h8;
			tgt(a[31:0]);
		end
		for (int i = 0; i < 22; i++) begin
			a = {2'h2, 32'($urandom)};
			a[6:3] = codes[i / 2];
			a[2:0] = 3'h0;
			if (i % 4 == 0) a[31:29] = 3'h0;
			stall <= 2'($urandom);
			cpu_op(a, i[0], 0, 0);
		end
		for (int i = 0; i < 24; i++) begin
			a = {2'h1, 3'(5 + i % 3), 29'($urandom)};
			a[6:3] = codes[$urandom % 10];
			a[2:0] = 3'h0;
			stall <= 2'($urandom);
			cpu_op(a, i[0], 0, 0);
		end
		for (int i = 0; i < 4; i++) begin
			a = {2'h3, 32'($urandom)};
			a[2:0] = 3'h0;
			cpu_op(a, i[0], i[1], 0);
		end
		reg_rd(8'h08, rdat);
		chk(rdat, a[31:0], "last address");
		for (int i = 0; i < 6; i++) begin
			a = {1'b0, i[0], 32'($urandom)};
			if (i[0]) a[31:29] = 3'($urandom % 5);
			cpu_op(a, i[1], 0, 1);
		end
		cpu_op(34'h2_0000_0004, 0, 0, 2);
		cpu_op(34'h2_0000_0068, 1, 0, 2);
		reg_rd(8'h04, rdat);
		chk(rdat[1], 1, "error flag set");
		reg_wr(8'h04, 32'h0000_0002);
		reg_rd(8'h04, rdat);
		chk(rdat[1], 0, "error flag cleared");
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
